// ---- core/csb_ctl_err.sv ----
`timescale 1ns/1ns
module csb_ctl_err #(
    parameter logic REV_LATE = 1'h1 // revision level, arbitrary default
) (
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic [csb_pkg::AW-1:0]        reg_addr,
    input  wire logic [csb_pkg::DW-1:0]        reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [csb_pkg::DW-1:0]        reg_rdata,
    input  wire logic                          widemem_pin,
    input  wire logic                          write_buffer_valid,
    input  wire logic                          locked_load_set,
    input  wire logic                          io_space_write,
    input  wire logic                          tag_addr_parity_err,
    input  wire logic                          tag_ctrl_parity_err,
    input  wire logic                          unmapped_addr_err,
    input  wire logic [csb_pkg::FAW-1:0]       fault_sysaddr,
    input  wire logic [csb_pkg::FAW-1:0]       origin_sysaddr,
    input  wire logic                          victim_read,
    input  wire logic                          victim_write,
    input  wire logic                          dma_cycle,
    input  wire logic [2:0]                    cpu_req_type,
    input  wire logic [2:0]                    dma_cmd,
    input  wire logic                          probe_req,
    output logic                               probe_grant,
    output logic                               l2_cache_on,
    output logic      [1:0]                    bus_arb_select,
    output csb_pkg::csb_arb_t                  arb_mode,
    output logic                               locked_load_flag,
    output logic                               irq
);

    // exact match decode, shared by read and write paths
    function automatic logic hit(input logic [csb_pkg::AW-1:0] a, input logic [csb_pkg::AW-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // 0x reads as cpu priority whatever the low bit holds
    function automatic csb_pkg::csb_arb_t arb_decode(input logic [1:0] f);
        if (!f[1])
            arb_decode = csb_pkg::ARB_CPU;
        else if (f[0])
            arb_decode = csb_pkg::ARB_DMA_STRONG;
        else
            arb_decode = csb_pkg::ARB_DMA;
    endfunction : arb_decode

    logic                     widemem_s;
    logic                     l2_on_r;
    logic [1:0]               arb_r;
    logic                     tap_r;
    logic                     tcp_r;
    logic                     nxm_r;
    logic                     lost_r;
    logic                     tap_nxt;
    logic                     tcp_nxt;
    logic                     nxm_nxt;
    logic                     lost_nxt;
    logic [2:0]               cause_r;
    logic                     vict_r;
    logic                     dma_r;
    logic [csb_pkg::FAW-1:0]  err_addr_r;
    logic                     llock_r;
    logic [csb_pkg::DW-1:0]   rdata_r;
    logic [csb_pkg::DW-1:0]   rd_nxt;
    logic                     wr_gen;
    logic                     wr_ed;
    logic                     wr_ists;
    logic                     wr_imsk;
    logic                     err_any;
    logic                     locked;
    logic                     capture;

    csb_irq_if irq_bus ();

    // strap comes from a pin, so it is resynchronised first
    csb_sync2 u_wide_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .din     (widemem_pin),
        .dout    (widemem_s)
    );

    csb_irq u_irq (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .bus     (irq_bus.irqblk)
    );

    // write decode
    assign wr_gen  = reg_wr && hit(reg_addr, csb_pkg::OFS_GEN_CTRL);
    assign wr_ed   = reg_wr && hit(reg_addr, csb_pkg::OFS_ERR_DIAG);
    assign wr_ists = reg_wr && hit(reg_addr, csb_pkg::OFS_IRQ_STS);
    assign wr_imsk = reg_wr && hit(reg_addr, csb_pkg::OFS_IRQ_MSK);

    // general control; bits other than enable and arbitration are dropped
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            l2_on_r <= csb_pkg::RST_L2_ON;
            arb_r   <= csb_pkg::RST_ARB;
        end
        else if (wr_gen)
        begin
            l2_on_r <= reg_wdata[csb_pkg::GC_L2_ON];
            arb_r   <= reg_wdata[csb_pkg::GC_ARB_HI:csb_pkg::GC_ARB_LO];
        end
    end

    // cache probes are gated off while the cache is disabled
    assign probe_grant    = probe_req & l2_on_r;
    assign l2_cache_on    = l2_on_r;
    assign bus_arb_select = arb_r;
    assign arb_mode       = arb_decode(arb_r);

    // the lock is simply the or of the primary flags, so it can never disagree with them
    assign err_any = tag_addr_parity_err | tag_ctrl_parity_err | unmapped_addr_err;
    assign locked  = tap_r | tcp_r | nxm_r;
    assign capture = err_any & ~locked;

    // primary flags set only while unlocked; a set beats a same-cycle clear
    always_comb
    begin
        tap_nxt  = (tap_r & ~(wr_ed & reg_wdata[csb_pkg::ED_TAP])) | (capture & tag_addr_parity_err);
        tcp_nxt  = (tcp_r & ~(wr_ed & reg_wdata[csb_pkg::ED_TCP])) | (capture & tag_ctrl_parity_err);
        nxm_nxt  = (nxm_r & ~(wr_ed & reg_wdata[csb_pkg::ED_NXM])) | (capture & unmapped_addr_err);
        lost_nxt = (lost_r & ~(wr_ed & reg_wdata[csb_pkg::ED_LOST])) | (err_any & locked);
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            tap_r  <= csb_pkg::RST_FLAG;
            tcp_r  <= csb_pkg::RST_FLAG;
            nxm_r  <= csb_pkg::RST_FLAG;
            lost_r <= csb_pkg::RST_FLAG;
        end
        else
        begin
            tap_r  <= tap_nxt;
            tcp_r  <= tcp_nxt;
            nxm_r  <= nxm_nxt;
            lost_r <= lost_nxt; // clearing lost alone never unlocks
        end
    end

    // capture address and cause on the unlocked error only; overflow errors leave them alone
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            err_addr_r <= csb_pkg::RST_ADDR;
            cause_r    <= csb_pkg::RST_CAUSE;
            vict_r     <= csb_pkg::RST_FLAG;
            dma_r      <= csb_pkg::RST_FLAG;
        end
        else if (capture)
        begin
            err_addr_r <= victim_read ? origin_sysaddr : fault_sysaddr;
            cause_r    <= dma_cycle ? dma_cmd : cpu_req_type;
            vict_r     <= victim_write & unmapped_addr_err;
            dma_r      <= dma_cycle;
        end
    end

    // lock for a locked load; a set in the same cycle as a clearing write wins
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            llock_r <= csb_pkg::RST_FLAG;
        else if (locked_load_set)
            llock_r <= 1'h1;
        else if (reg_wr || io_space_write)
            llock_r <= 1'h0;
    end

    assign locked_load_flag = llock_r;

    // interrupt events are the flag set terms, not the flag levels
    always_comb
    begin
        irq_bus.evt                   = '0;
        irq_bus.evt[csb_pkg::IRQ_TAP]  = capture & tag_addr_parity_err;
        irq_bus.evt[csb_pkg::IRQ_TCP]  = capture & tag_ctrl_parity_err;
        irq_bus.evt[csb_pkg::IRQ_NXM]  = capture & unmapped_addr_err;
        irq_bus.evt[csb_pkg::IRQ_LOST] = err_any & locked;
    end

    assign irq_bus.sts_wr = wr_ists;
    assign irq_bus.msk_wr = wr_imsk;
    assign irq_bus.wdata  = reg_wdata[csb_pkg::IRQ_N-1:0];
    assign irq            = irq_bus.irq;

    // read mux; reserved bits and unmapped addresses give zero
    always_comb
    begin
        rd_nxt = '0;
        if (hit(reg_addr, csb_pkg::OFS_GEN_CTRL))
        begin
            rd_nxt[csb_pkg::GC_L2_ON]                    = l2_on_r;
            rd_nxt[csb_pkg::GC_WIDE]                     = widemem_s;
            rd_nxt[csb_pkg::GC_ARB_HI:csb_pkg::GC_ARB_LO] = arb_r;
        end
        else if (hit(reg_addr, csb_pkg::OFS_ERR_DIAG))
        begin
            rd_nxt[csb_pkg::ED_WPEND]                        = write_buffer_valid;
            rd_nxt[csb_pkg::ED_LLOCK]                        = llock_r;
            rd_nxt[csb_pkg::ED_REV]                          = REV_LATE;
            rd_nxt[csb_pkg::ED_CAUSE_HI:csb_pkg::ED_CAUSE_LO] = cause_r;
            rd_nxt[csb_pkg::ED_VICT]                         = vict_r;
            rd_nxt[csb_pkg::ED_DMA]                          = dma_r;
            rd_nxt[csb_pkg::ED_NXM]                          = nxm_r;
            rd_nxt[csb_pkg::ED_TCP]                          = tcp_r;
            rd_nxt[csb_pkg::ED_TAP]                          = tap_r;
            rd_nxt[csb_pkg::ED_LOST]                         = lost_r;
        end
        else if (hit(reg_addr, csb_pkg::OFS_ERR_LO))
            rd_nxt = err_addr_r[csb_pkg::LOW-1:0];
        else if (hit(reg_addr, csb_pkg::OFS_ERR_HI))
            rd_nxt[csb_pkg::HIW-1:0] = err_addr_r[csb_pkg::FAW-1:csb_pkg::LOW];
        else if (hit(reg_addr, csb_pkg::OFS_IRQ_STS))
            rd_nxt[csb_pkg::IRQ_N-1:0] = irq_bus.sts;
        else if (hit(reg_addr, csb_pkg::OFS_IRQ_MSK))
            rd_nxt[csb_pkg::IRQ_N-1:0] = irq_bus.msk;
    end

    // read data stands for the one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            rdata_r <= csb_pkg::RST_RDATA;
        else if (reg_rd)
            rdata_r <= rd_nxt;
        else
            rdata_r <= csb_pkg::RST_RDATA;
    end

    assign reg_rdata = rdata_r;

    // checks

    a_probe_gate_off : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_gen && !reg_wdata[csb_pkg::GC_L2_ON]) |=> !probe_grant until wr_gen)
        else $error("probe granted with cache disabled");

    a_wide_strap_read : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_rd && hit(reg_addr, csb_pkg::OFS_GEN_CTRL)) |=> reg_rdata[csb_pkg::GC_WIDE] == $past(widemem_s))
        else $error("wide strap bit wrong");

    a_arb_field_write : assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_gen |=> (bus_arb_select == $past(reg_wdata[2:1])) && (arb_mode == arb_decode(bus_arb_select)))
        else $error("arbitration field not taken");

    a_err_lock_set : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!locked && err_any) |=> locked && (err_addr_r == $past(victim_read ? origin_sysaddr : fault_sysaddr)))
        else $error("error did not lock address");

    a_lost_only_set : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (locked && err_any) |=> lost_r && $stable(err_addr_r) && $stable(cause_r) && $stable(dma_r))
        else $error("locked error disturbed capture");

    a_unlock_on_clear : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_ed && !err_any && ((reg_wdata[3:1] & {nxm_r, tcp_r, tap_r}) == {nxm_r, tcp_r, tap_r})) |=> !locked)
        else $error("address stayed locked");

    a_pending_read : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_rd && hit(reg_addr, csb_pkg::OFS_ERR_DIAG))
        |=> reg_rdata[csb_pkg::ED_WPEND] == $past(write_buffer_valid))
        else $error("write pending bit wrong");

    a_llock_clear : assert property (@(posedge ref_clk) disable iff (sys_rst)
        ((reg_wr || io_space_write) && !locked_load_set) |=> !locked_load_flag)
        else $error("locked load not cleared by write");

    a_cause_capture : assert property (@(posedge ref_clk) disable iff (sys_rst)
        capture |=> cause_r == $past(dma_cycle ? dma_cmd : cpu_req_type)
        && vict_r == $past(victim_write & unmapped_addr_err))
        else $error("cause not captured");

    a_flag_w1c : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_ed && reg_wdata[csb_pkg::ED_LOST] && !err_any) |=> !lost_r)
        else $error("overflow flag not cleared");

    a_rdata_one_cycle : assert property (@(posedge ref_clk) disable iff (sys_rst)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data outside its cycle");

    a_l2_enable_write : assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_gen
        |=> l2_cache_on == $past(reg_wdata[csb_pkg::GC_L2_ON]))
        else $error("cache enable not taken");

    a_rev_bit_read : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_rd && hit(reg_addr, csb_pkg::OFS_ERR_DIAG))
        |=> reg_rdata[csb_pkg::ED_REV] == REV_LATE)
        else $error("revision bit wrong");

    a_lost_keeps_flags : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (locked && err_any && !wr_ed)
        |=> $stable({nxm_r, tcp_r, tap_r}) && $stable(vict_r))
        else $error("locked error changed flags");

    a_llock_set : assert property (@(posedge ref_clk) disable iff (sys_rst)
        locked_load_set
        |=> locked_load_flag)
        else $error("locked load not set");

    a_dma_capture : assert property (@(posedge ref_clk) disable iff (sys_rst)
        capture
        |=> dma_r == $past(dma_cycle))
        else $error("dma flag not captured");

    a_flags_unlocked : assert property (@(posedge ref_clk) disable iff (sys_rst)
        locked
        |=> !$rose(tap_r) && !$rose(tcp_r) && !$rose(nxm_r))
        else $error("primary flag set while locked");

    a_unmapped_w1c : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (wr_ed && reg_wdata[csb_pkg::ED_NXM] && !err_any)
        |=> !nxm_r)
        else $error("unmapped flag not cleared");

    a_err_addr_hold : assert property (@(posedge ref_clk) disable iff (sys_rst)
        !capture
        |=> $stable(err_addr_r))
        else $error("error address moved");

    a_victim_origin : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (capture && victim_read)
        |=> err_addr_r == $past(origin_sysaddr))
        else $error("victim address latched");

    a_diag_reserved : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_rd && hit(reg_addr, csb_pkg::OFS_ERR_DIAG))
        |=> reg_rdata[12:9] == 4'h0)
        else $error("diag reserved bits set");

    a_gen_reserved : assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_rd && hit(reg_addr, csb_pkg::OFS_GEN_CTRL))
        |=> {reg_rdata[15:6], reg_rdata[3], reg_rdata[0]} == 12'h0)
        else $error("control reserved bits set");

endmodule : csb_ctl_err

// ---- pkg/csb_pkg.sv ----
// Contract
// - l2 cache enable bit resets to zero; while zero the cache is never probed
// - read-only bit shows the wide-memory strap, one for the 128-bit memory interface
// - two-bit arbitration field: 0x cpu, 10 dma, 11 strong dma; resets to zero
// - a tag parity or unmapped-address error locks the captured error address
// - while locked any further error sets only the overflow flag, nothing else changes; the code also sets the overflow interrupt status bit
// - clearing all primary flags unlocks, whatever the overflow flag; software must clear them
// - read-only pending flag is one while the write buffer holds data; resets zero
// - locked-load flag shows the lock; any register or io-space write clears it
// - read-only bit shows the silicon revision as a fixed level
// - three-bit cause takes cpu request or dma command lines, locked with the address
// - victim flag is set when a victim write made an unmapped-address error
// - dma flag is set when a dma transaction caused the error, locked with the address
// - unmapped-address flag is write-one-to-clear, resets zero, sets only while unlocked
// - tag-control parity flag is write-one-to-clear, resets zero, sets only while unlocked
// - tag-address parity flag is write-one-to-clear, resets zero, sets only while unlocked
// - overflow flag is write-one-to-clear, resets zero, captures no address or cause
// - a primary error latches the faulting address into low and high address registers
// - on a victim read the originating transaction address is latched instead
package csb_pkg;

    localparam int AW = 34;
    localparam int DW = 16;
    localparam int FAW = 29; // system address bits 33:5
    localparam int LOW = 16; // low error address width
    localparam int HIW = 13; // high error address width

    // register byte addresses
    localparam logic [AW-1:0] OFS_GEN_CTRL = 34'h180000000;
    localparam logic [AW-1:0] OFS_ERR_DIAG = 34'h180000020;
    localparam logic [AW-1:0] OFS_ERR_LO   = 34'h180000080;
    localparam logic [AW-1:0] OFS_ERR_HI   = 34'h1800000a0;
    localparam logic [AW-1:0] OFS_IRQ_STS  = 34'h180000f80;
    localparam logic [AW-1:0] OFS_IRQ_MSK  = 34'h180000fa0;

    // general control fields
    localparam int GC_L2_ON  = 5;
    localparam int GC_WIDE   = 4;
    localparam int GC_ARB_LO = 1;
    localparam int GC_ARB_HI = 2;

    // error and diagnostic fields
    localparam int ED_WPEND    = 15;
    localparam int ED_LLOCK    = 14;
    localparam int ED_REV      = 13;
    localparam int ED_CAUSE_HI = 8;
    localparam int ED_CAUSE_LO = 6;
    localparam int ED_VICT     = 5;
    localparam int ED_DMA      = 4;
    localparam int ED_NXM      = 3;
    localparam int ED_TCP      = 2;
    localparam int ED_TAP      = 1;
    localparam int ED_LOST     = 0;

    // interrupt status and mask layout
    localparam int IRQ_TAP  = 0;
    localparam int IRQ_TCP  = 1;
    localparam int IRQ_NXM  = 2;
    localparam int IRQ_LOST = 3;
    localparam int IRQ_N    = 4;

    // reset values
    localparam logic            RST_L2_ON = 1'h0;
    localparam logic [1:0]      RST_ARB   = 2'h0;
    localparam logic            RST_FLAG  = 1'h0;
    localparam logic [2:0]      RST_CAUSE = 3'h0;
    localparam logic [FAW-1:0]  RST_ADDR  = 29'h0;
    localparam logic [IRQ_N-1:0] RST_IRQ  = 4'h0;
    localparam logic [DW-1:0]   RST_RDATA = 16'h0;

    typedef enum logic [1:0] {
        ARB_CPU        = 2'h0,
        ARB_DMA        = 2'h1,
        ARB_DMA_STRONG = 2'h3
    } csb_arb_t;

endpackage : csb_pkg

// ---- pkg/csb_irq_if.sv ----
`timescale 1ns/1ns
// event, status and mask traffic between the register core and the interrupt block
interface csb_irq_if;
    logic [csb_pkg::IRQ_N-1:0] evt;
    logic                      sts_wr;
    logic                      msk_wr;
    logic [csb_pkg::IRQ_N-1:0] wdata;
    logic [csb_pkg::IRQ_N-1:0] sts;
    logic [csb_pkg::IRQ_N-1:0] msk;
    logic                      irq;

    modport core (
        output evt, sts_wr, msk_wr, wdata,
        input  sts, msk, irq
    );
    modport irqblk (
        input  evt, sts_wr, msk_wr, wdata,
        output sts, msk, irq
    );
endinterface : csb_irq_if

// ---- core/csb_sync2.sv ----
`timescale 1ns/1ns
module csb_sync2 (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout
);
    logic meta_r;

    // two stages; only the second stage is read outside
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            meta_r <= 1'h0;
            dout   <= 1'h0;
        end
        else
        begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule : csb_sync2

// ---- core/csb_irq.sv ----
`timescale 1ns/1ns
module csb_irq (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    csb_irq_if.irqblk bus
);
    // sticky status per event; a new event beats a same-cycle clear
    genvar i;
    generate
        for (i = 0; i < csb_pkg::IRQ_N; i++)
        begin : g_sts
            always_ff @(posedge ref_clk)
            begin
                if (sys_rst)
                    bus.sts[i] <= csb_pkg::RST_IRQ[i];
                else
                    bus.sts[i] <= (bus.sts[i] & ~(bus.sts_wr & bus.wdata[i])) | bus.evt[i];
            end
        end
    endgenerate

    // mask register, one enables the matching status bit
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            bus.msk <= csb_pkg::RST_IRQ;
        else if (bus.msk_wr)
            bus.msk <= bus.wdata;
    end

    assign bus.irq = |(bus.sts & bus.msk);
endmodule : csb_irq

// ---- tb/csb_bus_model.sv ----
`timescale 1ns/1ns
// far-side cpu and dma masters: report one faulting cycle on request
module csb_bus_model (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        go,
    input  wire logic [2:0]  kind,
    input  wire logic [28:0] fa,
    input  wire logic [28:0] oa,
    input  wire logic [2:0]  qual,
    input  wire logic [2:0]  typ,
    output logic             tag_addr_parity_err,
    output logic             tag_ctrl_parity_err,
    output logic             unmapped_addr_err,
    output logic [28:0]      fault_sysaddr,
    output logic [28:0]      origin_sysaddr,
    output logic             victim_read,
    output logic             victim_write,
    output logic             dma_cycle,
    output logic [2:0]       cpu_req_type,
    output logic [2:0]       dma_cmd
);
    // error strobes last one cycle; idle qualifiers scramble so stale values never pass
    always_ff @(posedge ref_clk)
    begin
        {unmapped_addr_err, tag_ctrl_parity_err, tag_addr_parity_err} <= (go & ~sys_rst) ? kind : 3'h0;
        fault_sysaddr <= (go | sys_rst) ? fa : ~fault_sysaddr;
        origin_sysaddr <= (go | sys_rst) ? oa : ~origin_sysaddr;
        {victim_read, victim_write, dma_cycle} <= (go | sys_rst) ? qual : ~{victim_read, victim_write, dma_cycle};
        cpu_req_type <= (go | sys_rst) ? typ : ~cpu_req_type;
        dma_cmd <= (go | sys_rst) ? ~typ : ~dma_cmd; // differs from cpu type
    end
endmodule : csb_bus_model

// ---- tb/csb_ctl_err_tb.sv ----
`timescale 1ns/1ns
module csb_ctl_err_tb;
    localparam logic REV = 1'h1; // arbitrary revision level
    localparam logic [33:0] GEN = csb_pkg::OFS_GEN_CTRL;
    localparam logic [33:0] DIAG = csb_pkg::OFS_ERR_DIAG;
    logic                    ref_clk, sys_rst, reg_wr, reg_rd, widemem_pin, write_buffer_valid;
    logic                    locked_load_set, io_space_write, probe_req, probe_grant, l2_cache_on;
    logic                    locked_load_flag, irq, go, victim_read, victim_write, dma_cycle;
    logic                    tag_addr_parity_err, tag_ctrl_parity_err, unmapped_addr_err;
    logic [33:0]             reg_addr;
    logic [15:0]             reg_wdata, reg_rdata;
    logic [28:0]             fa, oa, fault_sysaddr, origin_sysaddr;
    logic [2:0]              kind, qual, typ, cpu_req_type, dma_cmd;
    logic [1:0]              bus_arb_select;
    csb_pkg::csb_arb_t       arb_mode;
    int                      errors = 0;
    int                      checked = 0;
    int                      cyc = 0;
    logic [15:0]             rw [6] = '{16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'hffff, 16'h0020};
    logic [15:0]             rr [6] = '{16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0036, 16'h0030};
    logic [1:0]              rm [6] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h3, 2'h0};

    csb_ctl_err #(.REV_LATE(REV)) dut (.*);
    csb_bus_model far (.*);

    // free-running clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // hang guard, well above the length of the sequence
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            errors++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [33:0] ad, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(negedge ref_clk); // let the written register settle before any check
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [33:0] ad, input logic [15:0] m, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk(reg_rdata & m, exp);
    endtask : rdc

    task automatic fire(input logic [2:0] k, input logic [28:0] f, input logic [28:0] o,
                        input logic [2:0] q, input logic [2:0] t);
        @(posedge ref_clk);
        go <= 1'b1;
        kind <= k;
        fa <= f;
        oa <= o;
        qual <= q;
        typ <= t;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : fire

    task automatic pulse_ll(input logic clr);
        @(posedge ref_clk);
        locked_load_set <= ~clr;
        io_space_write <= clr;
        @(posedge ref_clk);
        locked_load_set <= 1'b0;
        io_space_write <= 1'b0;
        @(negedge ref_clk);
    endtask : pulse_ll

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // main sequence
    initial
    begin
        {sys_rst, reg_wr, reg_rd, widemem_pin, write_buffer_valid, locked_load_set} = 6'h20;
        {io_space_write, probe_req, go, kind, qual, typ} = 12'h400;
        {reg_addr, reg_wdata, fa, oa} = 108'h0;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        widemem_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rdc(GEN, 16'hffff, 16'h0010);
        rdc(DIAG, 16'hffff, {2'h0, REV, 13'h0});
        chk({15'h0, irq}, 16'h0);
        $display("reset values done");
        for (int i = 0; i < 6; i++)
        begin
            wr(GEN, rw[i]);
            rdc(GEN, 16'hffff, rr[i]);
            chk({14'h0, arb_mode}, {14'h0, rm[i]});
            chk({15'h0, probe_grant}, {15'h0, rr[i][5]});
            chk({10'h0, l2_cache_on, 2'h0, bus_arb_select, 1'h0}, rr[i] & 16'h0026);
        end
        $display("control table done");
        fire(3'h1, 29'h0abc1234, 29'h0, 3'h1, 3'h2);
        rdc(DIAG, 16'hffff, 16'h2152);
        rdc(csb_pkg::OFS_ERR_LO, 16'hffff, 16'h1234);
        rdc(csb_pkg::OFS_ERR_HI, 16'hffff, 16'h0abc);
        rdc(csb_pkg::OFS_IRQ_STS, 16'hffff, 16'h0001);
        chk({15'h0, irq}, 16'h0);
        wr(csb_pkg::OFS_IRQ_MSK, 16'h000f);
        chk({15'h0, irq}, 16'h1);
        fire(3'h4, 29'h1555aaaa, 29'h0, 3'h0, 3'h6);
        rdc(DIAG, 16'hffff, 16'h2153);
        rdc(csb_pkg::OFS_ERR_LO, 16'hffff, 16'h1234);
        rdc(csb_pkg::OFS_IRQ_STS, 16'h0009, 16'h0009);
        wr(DIAG, 16'h0002);
        rdc(DIAG, 16'he00f, 16'h2001);
        fire(3'h4, 29'h0f0f0f0f, 29'h12345678, 3'h6, 3'h3);
        rdc(DIAG, 16'hffff, 16'h20e9);
        rdc(csb_pkg::OFS_ERR_LO, 16'hffff, 16'h5678);
        rdc(csb_pkg::OFS_ERR_HI, 16'hffff, 16'h1234);
        wr(DIAG, 16'hffff);
        rdc(DIAG, 16'he00f, 16'h2000);
        wr(csb_pkg::OFS_IRQ_STS, 16'h000f);
        chk({15'h0, irq}, 16'h0);
        $display("error capture done");
        pulse_ll(1'b0);
        chk({15'h0, locked_load_flag}, 16'h1);
        rdc(DIAG, 16'h4000, 16'h4000);
        pulse_ll(1'b1);
        chk({15'h0, locked_load_flag}, 16'h0);
        pulse_ll(1'b0);
        wr(34'h180000040, 16'hffff);
        @(negedge ref_clk);
        chk({15'h0, locked_load_flag}, 16'h0);
        rdc(34'h180000040, 16'hffff, 16'h0);
        $display("locked load done");
        @(posedge ref_clk);
        write_buffer_valid <= 1'b1;
        rdc(DIAG, 16'h8000, 16'h8000);
        @(posedge ref_clk);
        write_buffer_valid <= 1'b0;
        widemem_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rdc(GEN, 16'h0010, 16'h0000);
        $display("status pins done");
        fire(3'h2, 29'h1, 29'h0, 3'h7, 3'h5);
        rdc(DIAG, 16'h01ff, 16'h0094);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rdc(GEN, 16'h0026, 16'h0000);
        rdc(DIAG, 16'h01ff, 16'h0000);
        chk({15'h0, irq}, 16'h0);
        $display("mid-run reset done");
        close_out();
    end
endmodule : csb_ctl_err_tb
